// File: core/sff_parity.sv
// parity of the data bits actually carried in one character
`timescale 1ns/1ps
`default_nettype none
module sff_parity
   import sff_pkg::*;
(
   input  wire logic [7:0] data,
   input  wire logic       seven,
   input  wire logic       odd,
   output logic            par_bit
);
   // top data bit drops out of the sum in seven-bit frames
   assign par_bit = (^(data & {~seven, 7'h7f})) ^ odd;
endmodule
`default_nettype wire

// File: core/sff_pkg.sv
// constants, field layout and state types of the serial frame format block
package sff_pkg;
   localparam int ADDR_W = 5;
   // register byte offsets
   localparam logic [4:0] OFS_FORMAT  = 5'h00;
   localparam logic [4:0] OFS_DIVISOR = 5'h04;
   localparam logic [4:0] OFS_TXDATA  = 5'h08;
   localparam logic [4:0] OFS_RXDATA  = 5'h0c;
   localparam logic [4:0] OFS_STATUS  = 5'h10;
   // format control field positions
   localparam int FMT_MODE  = 7;
   localparam int FMT_SEVEN = 6;
   localparam int FMT_PAR   = 5;
   localparam int FMT_ODD   = 4;
   localparam int FMT_STOP  = 3;
   localparam int FMT_MULTI = 2;
   localparam int FMT_PS_HI = 1;
   localparam int FMT_PS_LO = 0;
   // status field positions
   localparam int ST_RXV  = 0;
   localparam int ST_PERR = 1;
   localparam int ST_FERR = 2;
   localparam int ST_OVR  = 3;
   localparam int ST_BUSY = 4;
   localparam int TX_MPB  = 8;
   // reset values
   localparam logic [7:0] FORMAT_RST  = 8'h00;
   localparam logic [7:0] DIVISOR_RST = 8'h00;
   localparam logic [8:0] TXDATA_RST  = 9'h0ff;
   // prescaler count masks: divide by 1, 8, 32, 128
   localparam logic [6:0] PS_MASK_1   = 7'h00;
   localparam logic [6:0] PS_MASK_8   = 7'h07;
   localparam logic [6:0] PS_MASK_32  = 7'h1f;
   localparam logic [6:0] PS_MASK_128 = 7'h7f;
   // sixteen baud ticks per bit
   localparam logic [3:0] OS_LAST    = 4'hf;
   localparam logic [3:0] OS_MID     = 4'h7;
   localparam logic [3:0] OS_SYNC_RX = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA,
                             TX_STOP1, TX_STOP2} sff_tx_st_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA,
                             RX_STOP} sff_rx_st_e;
endpackage

// File: core/sff_prescaler.sv
// clock prescaler and baud tick generator (sixteen ticks per bit)
`timescale 1ns/1ps
`default_nettype none
module sff_prescaler
   import sff_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] sel,
   input  wire logic [7:0] divisor,
   output logic            ps_tick,
   output logic            btick
);
   logic [6:0] ps_cnt;
   logic [6:0] mask;
   logic [7:0] bcnt;

   // division select
   always_comb begin
      unique case (sel)
         2'h0: mask = PS_MASK_1;
         2'h1: mask = PS_MASK_8;
         2'h2: mask = PS_MASK_32;
         2'h3: mask = PS_MASK_128;
      endcase
   end

   // free running count; a tick each time the masked bits are all ones
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ps_cnt  <= 7'h00;
         ps_tick <= 1'b0;
      end else begin
         ps_cnt  <= ps_cnt + 7'h01;
         ps_tick <= ((ps_cnt & mask) == mask);
      end
   end

   // baud tick every divisor+1 prescaled ticks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bcnt  <= 8'h00;
         btick <= 1'b0;
      end else begin
         btick <= 1'b0;
         if (ps_tick) begin
            if (bcnt >= divisor) begin
               bcnt  <= 8'h00;
               btick <= 1'b1;
            end else begin
               bcnt <= bcnt + 8'h01;
            end
         end
      end
   end

   property p_div8;
      @(posedge aclk) disable iff (!aresetn)
      (ps_tick && sel == 2'h1 && $past(sel) == 2'h1)
      |=> ##7 (ps_tick || sel != 2'h1);
   endproperty
   a_div8: assert property (p_div8) else $error("divide by 8 spacing");

   property p_div1;
      @(posedge aclk) disable iff (!aresetn)
      (sel == 2'h0 && $past(sel) == 2'h0 && $past(aresetn)) |-> ps_tick;
   endproperty
   a_div1: assert property (p_div1) else $error("undivided tick missing");
endmodule
`default_nettype wire

// File: core/sff_top.sv
// serial channel with format control register, behind an AXI4-Lite slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - even parity: transmitted data plus parity bit has an even ones count
// - even parity: receiver checks data plus parity ones count is even
// - odd parity: transmitted data plus parity bit has an odd ones count
// - odd parity: receiver checks data plus parity ones count is odd
// - odd select matters only with parity enabled in asynchronous mode
// - transmit one stop bit when stop select is 0, two when 1
// - receiver checks only the first stop bit
// - a low second stop bit is taken as the next start bit
// - stop length and multiprocessor bits ignored in synchronous mode
// - multiprocessor enable bit 2 selects multiprocessor format
// - multiprocessor mode neither adds nor checks parity
// - prescaler select divides the clock by 1, 8, 32 or 128
// - mode bit 7: 0 asynchronous, 1 clocked synchronous
// - parity enable bit 5 adds and checks parity in asynchronous mode
// - character length bit: 0 eight data bits, 1 seven in asynchronous mode (synchronous mode always eight), LSB first
module sff_top
   import sff_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              rxd_pin,
   output logic                   txd_pin,
   output logic                   sck_pin
);
   logic [7:0] serial_format_control;
   logic [7:0] bit_rate_divisor_register;
   logic [8:0] tx_data;
   logic [7:0] rx_data;
   logic       rx_mpb;
   logic       rx_valid, par_err, frm_err, ovr_err;
   logic       wr_en, rd_en, ps_tick, btick;
   logic       sync_mode, seven_bit_select, parity_enable;
   logic       multiproc_enable, par_odd, two_stop;
   logic       tx_go, tx_bit_end, rx_sample, rx_done, rx_perr_now;
   logic       tx_par, rx_par, rx_s1, rx_s2, rx_extra, rx_stop_bit;
   logic [2:0] last_idx, tx_cnt, rx_cnt;
   logic [3:0] tx_os, rx_os;
   logic [7:0] rx_shift;
   sff_tx_st_e tx_st;
   sff_rx_st_e rx_st;

   // live format decode; synchronous mode masks the async-only options
   assign sync_mode        = serial_format_control[FMT_MODE];
   assign seven_bit_select = serial_format_control[FMT_SEVEN] & ~sync_mode;
   assign multiproc_enable = serial_format_control[FMT_MULTI]
                             & ~sync_mode;
   assign parity_enable    = serial_format_control[FMT_PAR] & ~sync_mode
                             & ~multiproc_enable;
   assign par_odd          = serial_format_control[FMT_ODD];
   assign two_stop         = serial_format_control[FMT_STOP] & ~sync_mode;
   assign last_idx         = seven_bit_select ? 3'h6 : 3'h7;

   sff_prescaler u_presc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sel     (serial_format_control[FMT_PS_HI:FMT_PS_LO]),
      .divisor (bit_rate_divisor_register),
      .ps_tick (ps_tick),
      .btick   (btick)
   );

   sff_parity u_txpar (
      .data    (tx_data[7:0]),
      .seven   (seven_bit_select),
      .odd     (par_odd),
      .par_bit (tx_par)
   );

   sff_parity u_rxpar (
      .data    (rx_shift),
      .seven   (seven_bit_select),
      .odd     (par_odd),
      .par_bit (rx_par)
   );

   // write channel: address and data are taken together in one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
      end else if (awready) begin
         awready <= 1'b0;
         wready  <= 1'b0;
      end else if (awvalid && wvalid && !bvalid) begin
         awready <= 1'b1;
         wready  <= 1'b1;
      end
   end
   assign wr_en = awready && awvalid && wvalid;

   // write response; unmapped offsets answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_en) begin
         bvalid <= 1'b1;
         unique case (awaddr)
            OFS_FORMAT, OFS_DIVISOR, OFS_TXDATA,
            OFS_RXDATA, OFS_STATUS: bresp <= RESP_OKAY;
            default:                bresp <= RESP_SLVERR;
         endcase
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // software-written registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_format_control     <= FORMAT_RST;
         bit_rate_divisor_register <= DIVISOR_RST;
      end else if (wr_en && wstrb[0]) begin
         if (awaddr == OFS_FORMAT)
            serial_format_control <= wdata[7:0];
         if (awaddr == OFS_DIVISOR)
            bit_rate_divisor_register <= wdata[7:0];
      end
   end

   // a write to tx data while the transmitter is busy is dropped
   assign tx_go = wr_en && wstrb[0] && awaddr == OFS_TXDATA
                  && tx_st == TX_IDLE;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         tx_data <= TXDATA_RST;
      else if (tx_go)
         tx_data <= {wdata[TX_MPB] & wstrb[1], wdata[7:0]};
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn)
         arready <= 1'b0;
      else if (arready)
         arready <= 1'b0;
      else if (arvalid && !rvalid)
         arready <= 1'b1;
   end
   assign rd_en = arready && arvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= RESP_OKAY;
      end else if (rd_en) begin
         rvalid <= 1'b1;
         rresp  <= RESP_OKAY;
         unique case (araddr)
            OFS_FORMAT:  rdata <= {24'h00_0000, serial_format_control};
            OFS_DIVISOR: rdata <= {24'h00_0000, bit_rate_divisor_register};
            OFS_TXDATA:  rdata <= {23'h00_0000, tx_data};
            OFS_RXDATA:  rdata <= {23'h00_0000, rx_mpb, rx_data};
            OFS_STATUS:  rdata <= {27'h000_0000, tx_st != TX_IDLE,
                                   ovr_err, frm_err, par_err, rx_valid};
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // transmitter bit timing: sixteen baud ticks per bit
   assign tx_bit_end = btick && tx_os == OS_LAST;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         tx_os <= 4'h0;
      else if (tx_go)
         tx_os <= 4'h0;
      else if (btick)
         tx_os <= tx_os + 4'h1;
   end

   // transmit frame sequencer; synchronous mode sends bare data bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_st  <= TX_IDLE;
         tx_cnt <= 3'h0;
      end else if (tx_go) begin
         tx_st  <= sync_mode ? TX_DATA : TX_START;
         tx_cnt <= 3'h0;
      end else if (tx_bit_end) begin
         unique case (tx_st)
            TX_IDLE:  tx_st <= TX_IDLE;
            TX_START: tx_st <= TX_DATA;
            TX_DATA: begin
               tx_cnt <= tx_cnt + 3'h1;
               if (tx_cnt == last_idx) begin
                  if (parity_enable || multiproc_enable)
                     tx_st <= TX_EXTRA;
                  else
                     tx_st <= sync_mode ? TX_IDLE : TX_STOP1;
               end
            end
            TX_EXTRA: tx_st <= TX_STOP1;
            TX_STOP1: tx_st <= two_stop ? TX_STOP2 : TX_IDLE;
            TX_STOP2: tx_st <= TX_IDLE;
         endcase
      end
   end

   // line level; extra bit is the parity bit or the multiprocessor bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txd_pin <= 1'b1;
         sck_pin <= 1'b1;
      end else begin
         sck_pin <= !(sync_mode && tx_st == TX_DATA) || tx_os[3];
         unique case (tx_st)
            TX_START: txd_pin <= 1'b0;
            TX_DATA:  txd_pin <= tx_data[tx_cnt];
            TX_EXTRA: txd_pin <= multiproc_enable ? tx_data[TX_MPB]
                                                  : tx_par;
            default:  txd_pin <= 1'b1;
         endcase
      end
   end

   // two flops bring the receive pin into the clock domain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else begin
         rx_s1 <= rxd_pin;
         rx_s2 <= rx_s1;
      end
   end

   // receive timing: start confirmed at mid bit, then one sample per bit
   assign rx_sample = btick && rx_os == OS_LAST;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         rx_os <= 4'h0;
      else if (rx_st == RX_IDLE)
         rx_os <= sync_mode ? OS_SYNC_RX : 4'h0;
      else if (btick)
         rx_os <= (rx_st == RX_START && rx_os == OS_MID) ? 4'h0
                                                         : rx_os + 4'h1;
   end

   // a character completes at the first stop bit or the last sync bit
   assign rx_done = rx_sample && (rx_st == RX_STOP
                    || (sync_mode && rx_st == RX_DATA && rx_cnt == last_idx));

   // receive sequencer; only the first stop bit is ever looked at
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_st    <= RX_IDLE;
         rx_cnt   <= 3'h0;
         rx_shift <= 8'h00;
         rx_extra <= 1'b0;
      end else begin
         unique case (rx_st)
            RX_IDLE: begin
               rx_cnt <= 3'h0;
               // a low line right after the first stop starts a new
               // character, so a zero second stop bit is a start bit
               if (sync_mode ? tx_go : !rx_s2) begin
                  rx_st    <= sync_mode ? RX_DATA : RX_START;
                  rx_shift <= 8'h00;
               end
            end
            RX_START: begin
               if (btick && rx_os == OS_MID)
                  rx_st <= rx_s2 ? RX_IDLE : RX_DATA;
            end
            RX_DATA: begin
               if (rx_sample) begin
                  rx_shift[rx_cnt] <= rx_s2;
                  rx_cnt           <= rx_cnt + 3'h1;
                  if (rx_cnt == last_idx) begin
                     if (sync_mode)
                        rx_st <= RX_IDLE;
                     else if (parity_enable || multiproc_enable)
                        rx_st <= RX_EXTRA;
                     else
                        rx_st <= RX_STOP;
                  end
               end
            end
            RX_EXTRA: begin
               if (rx_sample) begin
                  rx_extra <= rx_s2;
                  rx_st    <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_sample)
                  rx_st <= RX_IDLE;
            end
         endcase
      end
   end

   // check results; parity compared only while parity is in force
   assign rx_stop_bit = rx_s2;
   assign rx_perr_now = parity_enable && (rx_par != rx_extra);

   // received character and flags; a new event beats a clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data  <= 8'h00;
         rx_mpb   <= 1'b0;
         rx_valid <= 1'b0;
         par_err  <= 1'b0;
         frm_err  <= 1'b0;
         ovr_err  <= 1'b0;
      end else begin
         if (rd_en && araddr == OFS_RXDATA)
            rx_valid <= 1'b0;
         if (wr_en && wstrb[0] && awaddr == OFS_STATUS) begin
            if (wdata[ST_PERR]) par_err <= 1'b0;
            if (wdata[ST_FERR]) frm_err <= 1'b0;
            if (wdata[ST_OVR])  ovr_err <= 1'b0;
         end
         if (rx_done) begin
            rx_data  <= rx_shift;
            // the last sync bit is shifted in this same cycle
            if (sync_mode)
               rx_data[7] <= rx_s2;
            rx_mpb   <= multiproc_enable & rx_extra;
            rx_valid <= 1'b1;
            if (rx_valid)
               ovr_err <= 1'b1;
            if (rx_perr_now)
               par_err <= 1'b1;
            if (!sync_mode && !rx_stop_bit)
               frm_err <= 1'b1;
         end
      end
   end

   property p_tx_parity;
      @(posedge aclk) disable iff (!aresetn)
      ($past(tx_st) == TX_EXTRA && $past(parity_enable) && $stable(tx_data))
      |-> (txd_pin ^ (^(tx_data[7:0] & {~seven_bit_select, 7'h7f}))) == par_odd;
   endproperty
   a_tx_parity: assert property (p_tx_parity) else $error("tx parity bit wrong");

   property p_rx_parity;
      @(posedge aclk) disable iff (!aresetn)
      (rx_done && parity_enable && rx_par != rx_extra) |=> par_err;
   endproperty
   a_rx_parity: assert property (p_rx_parity) else $error("parity error not flagged");

   property p_no_par_check;
      @(posedge aclk) disable iff (!aresetn)
      (!par_err && rx_done && !parity_enable && !(wr_en && awaddr == OFS_STATUS))
      |=> !par_err;
   endproperty
   a_no_par_check: assert property (p_no_par_check) else $error("parity checked while off");

   property p_two_stop;
      @(posedge aclk) disable iff (!aresetn)
      (tx_st == TX_STOP1 && tx_bit_end && two_stop) |=> tx_st == TX_STOP2 ##2 txd_pin;
   endproperty
   a_two_stop: assert property (p_two_stop) else $error("second stop bit missing");

   property p_one_stop;
      @(posedge aclk) disable iff (!aresetn)
      (tx_st == TX_STOP1 && tx_bit_end && !two_stop && !tx_go) |=> tx_st == TX_IDLE;
   endproperty
   a_one_stop: assert property (p_one_stop) else $error("extra stop bit sent");

   property p_first_stop_only;
      @(posedge aclk) disable iff (!aresetn)
      (rx_st == RX_STOP && rx_sample) |=> rx_st == RX_IDLE;
   endproperty
   a_first_stop_only: assert property (p_first_stop_only) else $error("rx held past first stop");

   property p_sync_frame;
      @(posedge aclk) disable iff (!aresetn)
      sync_mode |-> !(tx_st inside {TX_START, TX_EXTRA, TX_STOP1, TX_STOP2});
   endproperty
   a_sync_frame: assert property (p_sync_frame) else $error("framing bits in sync mode");

   property p_mp_extra;
      @(posedge aclk) disable iff (!aresetn)
      ($past(tx_st) == TX_EXTRA && $past(multiproc_enable))
      |-> txd_pin == $past(tx_data[TX_MPB]);
   endproperty
   a_mp_extra: assert property (p_mp_extra) else $error("multiprocessor bit not sent");

   property p_seven_bits;
      @(posedge aclk) disable iff (!aresetn)
      (tx_st == TX_DATA && seven_bit_select) |-> tx_cnt != 3'h7;
   endproperty
   a_seven_bits: assert property (p_seven_bits) else $error("eighth bit sent in 7-bit mode");
endmodule
`default_nettype wire

// File: test/serial_frame_format_control_test.sv
// bench for the format control block: register bus tasks and frame tests
`timescale 1ns/1ps
`default_nettype none
module serial_frame_format_control_test
   import sff_pkg::*;
;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        txd_pin, sck_pin, rxd;
   logic [1:0]  bresp, rresp, rs;
   logic [11:0] bt = 12'h010, got;
   logic [3:0]  nb = 4'ha;
   int          t0, fails = 0, num_checks = 0, sck_falls = 0;
   int          dv[4] = '{1, 8, 32, 128};

   always #25 aclk = ~aclk;
   // counts serial clock periods in synchronous mode
   always @(negedge sck_pin) sck_falls++;

   sff_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .rxd_pin(rxd), .txd_pin(txd_pin), .sck_pin(sck_pin));
   sff_remote rem (.aclk(aclk), .txd(txd_pin), .bt(bt), .nb(nb), .rxd(rxd),
      .got(got), .t0(t0));

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 1'h0;
      tw = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (awready === 1'h1) begin
            ta = 1'h1;
            awvalid <= 1'h0;
         end
         if (wready === 1'h1) begin
            tw = 1'h1;
            wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'h1);
      rs = bresp;
      bready <= 1'h0;
   endtask
   task automatic rdr(input logic [4:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge aclk); while (rvalid !== 1'h1);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask
   // one character out; line bits and frame length worked out here
   task automatic txc(input logic [7:0] f, input logic [8:0] d);
      logic [11:0] e, m;
      int n, len, tol;
      n = f[FMT_SEVEN] ? 7 : 8;
      e = {4'h0, d[7:0]};
      if (n == 7) e[7] = 1'h0;
      if (f[FMT_MULTI]) e[n] = d[TX_MPB];
      else if (f[FMT_PAR]) e[n] = ^e ^ f[FMT_ODD];
      if (f[FMT_MULTI] || f[FMT_PAR]) n = n + 1;
      e[n] = 1'h1;
      e[n + 1] = 1'h1;
      n = n + 1 + f[FMT_STOP];
      m = (12'h001 << n) - 12'h001;
      bt = 12'(16 * dv[f[1:0]]);
      nb = 4'(n);
      wr(OFS_FORMAT, {24'h0, f});
      wr(OFS_TXDATA, {23'h0, d});
      repeat (2) @(posedge aclk);
      do rdr(OFS_STATUS); while (rd[ST_BUSY] !== 1'h0);
      len = rem.cyc - t0 - (1 + n) * bt;
      tol = bt / 4 + 8;
      chk("line_bits", {20'h0, e & m}, {20'h0, got & m});
      chk("frame_len", 32'h1, {31'h0, len <= tol && len >= -tol});
      $display("test tx format %h done", f);
   endtask
   // one or two characters in, then status and received data
   task automatic rxc(input logic [7:0] f, input logic [19:0] b, input int n,
                      input logic [31:0] st, input logic [31:0] dat);
      bt = 12'h010;
      wr(OFS_FORMAT, {24'h0, f});
      rem.send(b, n);
      repeat (4) @(posedge aclk);
      rdr(OFS_STATUS);
      chk("rx_status", st, rd);
      rdr(OFS_RXDATA);
      chk("rx_data", dat, rd);
      wr(OFS_STATUS, 32'h0000000e);
      $display("test rx format %h done", f);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // longest run is the divide-by-128 frame, far below this span
   initial begin
      repeat (90000) @(posedge aclk);
      fails++;
      end_sim;
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rdr(OFS_FORMAT);
      chk("format_rst", {24'h0, FORMAT_RST}, rd);
      rdr(OFS_TXDATA);
      chk("txdata_rst", {23'h0, TXDATA_RST}, rd);
      rdr(5'h14);
      chk("unmapped_rd", {30'h0, RESP_SLVERR}, {30'h0, rs});
      wr(5'h14, 32'h000000ff);
      chk("unmapped_wr", {30'h0, RESP_SLVERR}, {30'h0, rs});
      wr(OFS_DIVISOR, 32'h0);
      wr(OFS_FORMAT, 32'h0000003d);
      rdr(OFS_FORMAT);
      chk("format_rw", 32'h0000003d, rd);
      $display("test registers done");
      txc(8'h00, 9'h0b5);
      txc(8'h20, 9'h0b5);
      txc(8'h30, 9'h0b5);
      txc(8'h10, 9'h0b5);
      txc(8'h70, 9'h0b5);
      txc(8'h60, 9'h0b5);
      txc(8'h08, 9'h0b5);
      txc(8'h34, 9'h1b5);
      txc(8'h24, 9'h0b5);
      txc(8'h01, 9'h055);
      txc(8'h02, 9'h055);
      txc(8'h03, 9'h055);
      rxc(8'h20, 20'h003b5, 10, 32'h1, 32'h0b5);
      rxc(8'h20, 20'h002b5, 10, 32'h3, 32'h0b5);
      rxc(8'h30, 20'h002b5, 10, 32'h1, 32'h0b5);
      rxc(8'h30, 20'h003b5, 10, 32'h3, 32'h0b5);
      rxc(8'h10, 20'h001b5, 9, 32'h1, 32'h0b5);
      rxc(8'h34, 20'h003b5, 10, 32'h1, 32'h1b5);
      rxc(8'h70, 20'h001b5, 9, 32'h1, 32'h035);
      rxc(8'h08, 20'h68d5a, 19, 32'h9, 32'h0a3);
      rxc(8'h00, 20'h002b5, 10, 32'h5, 32'h0b5);
      sck_falls = 0;
      wr(OFS_FORMAT, 32'h0000008c);
      wr(OFS_TXDATA, 32'h000000b5);
      repeat (2) @(posedge aclk);
      do rdr(OFS_STATUS); while (rd[ST_BUSY] !== 1'h0);
      chk("sync_clocks", 32'h8, sck_falls);
      $display("test sync done");
      end_sim;
   end
endmodule
`default_nettype wire

// File: test/sff_remote.sv
// remote serial station: samples the device's line and sends it frames
`timescale 1ns/1ps
`default_nettype none
module sff_remote (
   input  wire logic        aclk,
   input  wire logic        txd,
   input  wire logic [11:0] bt,
   input  wire logic [3:0]  nb,
   output logic             rxd,
   output logic [11:0]      got,
   output int               t0
);
   int cyc = 0;
   initial rxd = 1'h1;
   initial got = 12'h000;
   // free cycle count, used to time whole frames
   always @(posedge aclk) begin
      cyc <= cyc + 1;
   end
   // mid-bit sampling after a start edge; a short glitch is no start
   initial forever begin
      @(negedge txd);
      t0 = cyc;
      repeat (bt / 2) @(posedge aclk);
      if (txd === 1'h0) begin
         for (int i = 0; i < nb; i++) begin
            repeat (bt) @(posedge aclk);
            got[i] = txd;
         end
      end
   end
   // start bit, then n bits lsb first; the caller ends with stop bits
   task automatic send(input logic [19:0] b, input int n);
      rxd <= 1'h0;
      repeat (bt) @(posedge aclk);
      for (int i = 0; i < n; i++) begin
         rxd <= b[i];
         repeat (bt) @(posedge aclk);
      end
   endtask
endmodule
`default_nettype wire
